// ==== design/sys_clock_gate.sv ====
/*
  System clock gate, power mode and short I/O page logic with an APB slave.
  Assumes pclk is the master clock; gated clocks are delivered as one-cycle
  enable pulses at half rate, consumed by peripherals on pclk.
*/
`timescale 1ns/1ps
`include "sys_clock_params.svh"
module sys_clock_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sys_clock_pkg::power_req_type power_req,
  input wire sys_clock_pkg::wake_type wake,
  input wire logic periph_irq_unmasked,
  input wire logic off_chip_program_select,
  input wire logic [5:0] short_offset,
  output logic [23:0] short_address,
  output logic debug_jtag_blocked,
  output logic core_clock_en,
  output logic periph_clock_en,
  output logic [15:0] gate_one_clock_en,
  output logic second_controller_area_clock_en,
  output logic can_first_msg_drop,
  output logic [1:0] power_mode
);
  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] peripheral_clock_gate_one_reg;
  logic peripheral_clock_gate_two_reg;
  logic [1:0] short_io_page_high_reg;
  logic [15:0] short_io_page_low_reg;
  logic [17:0] page_pipe_reg [0:`PAGE_DELAY-1];
  logic half_reg;
  sys_clock_pkg::power_mode_type mode_reg;
  logic can_woke_reg;
  logic wr_acc;
  logic rd_acc;
  logic [3:0] idx;

  assign idx = paddr[5:2];
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;

  // ****************************************
  // Shared decode helpers
  // ****************************************
  // Register write strobe: only the access edge of an APB write counts
  function automatic logic write_hit(input logic acc, input logic [3:0] at, input logic [3:0] target);
    return acc && at == target;
  endfunction

  // Live half-rate tick for peripherals: kept in Run and Wait, never in Stop
  // One source for all peripheral enables keeps them phase aligned
  function automatic logic periph_tick(input logic half, input sys_clock_pkg::power_mode_type mode);
    return !half && mode != sys_clock_pkg::MODE_STOP;
  endfunction

  // ****************************************
  // Clock gate registers
  // ****************************************
  // One-bit-per-peripheral gate; 1 passes the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_clock_gate_one_reg <= `RESET_GATE_ONE;
      peripheral_clock_gate_two_reg <= 1'b1;
    end else if (write_hit(wr_acc, idx, `IDX_GATE_ONE)) begin
      peripheral_clock_gate_one_reg <= pwdata[15:0]; // [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE22]
    end else if (write_hit(wr_acc, idx, `IDX_GATE_TWO)) begin
      peripheral_clock_gate_two_reg <= pwdata[0]; // [RULE8]
    end
  end

  // ****************************************
  // Short I/O page registers
  // ****************************************
  // Both reset to ones so short addressing hits debug space
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_io_page_high_reg <= 2'h3; // [RULE12]
      short_io_page_low_reg <= `RESET_PAGE; // [RULE12]
    end else if (write_hit(wr_acc, idx, `IDX_PAGE_HIGH)) begin
      short_io_page_high_reg <= pwdata[1:0]; // [RULE10]
    end else if (write_hit(wr_acc, idx, `IDX_PAGE_LOW)) begin
      short_io_page_low_reg <= pwdata[15:0]; // [RULE11]
    end
  end

  // Pipeline models the three-cycle delay before a new page is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PAGE_DELAY; i++) begin
        page_pipe_reg[i] <= 18'h3FFFF;
      end
    end else begin
      page_pipe_reg[0] <= {short_io_page_high_reg, short_io_page_low_reg}; // [RULE13]
      for (int i = 1; i < `PAGE_DELAY; i++) begin
        page_pipe_reg[i] <= page_pipe_reg[i-1];
      end
    end
  end

  // Effective address: page bits above, instruction offset below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_address <= 24'hFFFFC0;
      debug_jtag_blocked <= 1'b0;
    end else begin
      short_address <= {page_pipe_reg[`PAGE_DELAY-2], short_offset}; // [RULE9] [RULE13]
      debug_jtag_blocked <= off_chip_program_select &&
        (page_pipe_reg[`PAGE_DELAY-2] != 18'h3FFFF); // [RULE14]
    end
  end

  // ****************************************
  // Power modes
  // ****************************************
  // Stop leaves only on its wake events; Wait leaves on an unmasked irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= sys_clock_pkg::MODE_RUN;
      can_woke_reg <= 1'b0;
    end else begin
      unique case (mode_reg)
        sys_clock_pkg::MODE_RUN: begin
          can_woke_reg <= 1'b0;
          if (power_req.stop_req) begin
            mode_reg <= sys_clock_pkg::MODE_STOP;
          end else if (power_req.wait_req) begin
            mode_reg <= sys_clock_pkg::MODE_WAIT;
          end
        end
        sys_clock_pkg::MODE_WAIT: begin
          if (periph_irq_unmasked) begin
            mode_reg <= sys_clock_pkg::MODE_RUN; // [RULE18]
          end
        end
        sys_clock_pkg::MODE_STOP: begin
          if (|wake) begin
            mode_reg <= sys_clock_pkg::MODE_RUN; // [RULE19]
            can_woke_reg <= wake.can_activity; // [RULE20]
          end
        end
        default: mode_reg <= sys_clock_pkg::MODE_RUN;
      endcase
    end
  end

  // ****************************************
  // Clock enables
  // ****************************************
  // Half-rate toggle; enables change only with the whole tick so no runt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg; // [RULE15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clock_en <= 1'b0;
      periph_clock_en <= 1'b0;
      gate_one_clock_en <= 16'h0000;
      second_controller_area_clock_en <= 1'b0;
      can_first_msg_drop <= 1'b0;
      power_mode <= 2'b00;
    end else begin
      power_mode <= mode_reg;
      can_first_msg_drop <= can_woke_reg; // [RULE20]
      core_clock_en <= ~half_reg && mode_reg == sys_clock_pkg::MODE_RUN; // [RULE16] [RULE17]
      periph_clock_en <= periph_tick(half_reg, mode_reg); // [RULE21]
      gate_one_clock_en <= {16{periph_tick(half_reg, mode_reg)}} &
        peripheral_clock_gate_one_reg; // [RULE1] [RULE23]
      second_controller_area_clock_en <= periph_tick(half_reg, mode_reg) &&
        peripheral_clock_gate_two_reg; // [RULE1] [RULE8] [RULE23]
    end
  end

  // ****************************************
  // APB read and response
  // ****************************************
  // Read data latched in setup; zero-wait access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= `PSLVERR_NONE;
      if (rd_acc) begin
        unique case (idx)
          `IDX_GATE_ONE: prdata <= {16'h0000, peripheral_clock_gate_one_reg};
          `IDX_GATE_TWO: prdata <= {31'h0, peripheral_clock_gate_two_reg}; // [RULE7]
          `IDX_PAGE_HIGH: prdata <= {16'h0000, `PAGE_HIGH_ONES | {14'h0, short_io_page_high_reg}}; // [RULE10]
          `IDX_PAGE_LOW: prdata <= {16'h0000, short_io_page_low_reg};
          `IDX_POWER_CTRL: prdata <= {30'h0, mode_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_page_delay_three: assert property (@(posedge pclk) disable iff (!presetn)
    ##3 short_address[23:6] == $past({short_io_page_high_reg, short_io_page_low_reg}, 3)) // [RULE13]
    else $error("short address page not delayed three cycles");
  a_core_off_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $past(mode_reg) == sys_clock_pkg::MODE_WAIT |-> !core_clock_en) // [RULE17]
    else $error("core clock running in wait");
  a_gate_zero_off: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(peripheral_clock_gate_one_reg[0]) |-> !gate_one_clock_en[0]) // [RULE1]
    else $error("gated clock passed while bit clear");
  a_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
    periph_clock_en |=> !periph_clock_en) // [RULE15]
    else $error("peripheral clock above half rate");
  a_gate_two_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $past(rd_acc && idx == `IDX_GATE_TWO) |-> prdata[31:1] == 31'h0) // [RULE7]
    else $error("gate two reserved bits not zero");
  a_stop_stays: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg == sys_clock_pkg::MODE_STOP && !(|wake) |=> mode_reg == sys_clock_pkg::MODE_STOP) // [RULE19]
    else $error("stop left without wake event");
  a_wait_wakes: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg == sys_clock_pkg::MODE_WAIT && periph_irq_unmasked |=> mode_reg == sys_clock_pkg::MODE_RUN) // [RULE18]
    else $error("wait not left on interrupt");
  a_jtag_block: assert property (@(posedge pclk) disable iff (!presetn)
    debug_jtag_blocked |-> $past(off_chip_program_select)) // [RULE14]
    else $error("debug blocked without off-chip select");

  // ****************************************
  // Power mode sequences
  // ****************************************
  // Steps of the mode machine; stop wins over wait in Run
  sequence s_wait_entry;
    mode_reg == sys_clock_pkg::MODE_RUN && !power_req.stop_req && power_req.wait_req;
  endsequence
  sequence s_stop_entry;
    mode_reg == sys_clock_pkg::MODE_RUN && power_req.stop_req;
  endsequence
  sequence s_can_exit;
    mode_reg == sys_clock_pkg::MODE_STOP && wake.can_activity;
  endsequence
  sequence s_run_idle;
    mode_reg == sys_clock_pkg::MODE_RUN && !power_req.stop_req && !power_req.wait_req;
  endsequence

  // Mode transitions
  a_wait_entry: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    s_wait_entry |=> mode_reg == sys_clock_pkg::MODE_WAIT)
    else $error("wait request not taken");
  a_stop_entry: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
    s_stop_entry |=> mode_reg == sys_clock_pkg::MODE_STOP)
    else $error("stop request not taken");
  a_run_stays: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    s_run_idle |=> mode_reg == sys_clock_pkg::MODE_RUN)
    else $error("run left without request");
  a_wait_holds: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    mode_reg == sys_clock_pkg::MODE_WAIT && !periph_irq_unmasked |=> mode_reg == sys_clock_pkg::MODE_WAIT)
    else $error("wait left without interrupt");
  a_wake_exits: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
    mode_reg == sys_clock_pkg::MODE_STOP && (|wake) |=> mode_reg == sys_clock_pkg::MODE_RUN)
    else $error("stop not left on wake event");
  a_mode_out: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    power_mode == $past(mode_reg))
    else $error("power mode output not registered mode");

  // Lost first message after a bus-activity wake
  a_can_drop_mark: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
    s_can_exit |=> ##1 can_first_msg_drop)
    else $error("first message drop not flagged");
  a_drop_needs_can: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
    can_first_msg_drop |-> $past(mode_reg, 2) == sys_clock_pkg::MODE_STOP)
    else $error("message drop without stop exit");
  a_drop_one_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
    can_first_msg_drop |=> !can_first_msg_drop)
    else $error("message drop longer than one cycle");

  // ****************************************
  // Clock enable checks
  // ****************************************
  // First edge after reset still shows reset values, hence the presetn guard
  a_core_run_only: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    core_clock_en |-> $past(mode_reg) == sys_clock_pkg::MODE_RUN)
    else $error("core clock outside run");
  a_core_ticks: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    $past(presetn) && $past(mode_reg) == sys_clock_pkg::MODE_RUN && !$past(half_reg) |-> core_clock_en)
    else $error("core tick missing in run");
  a_wait_periph: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    $past(presetn) && $past(mode_reg) == sys_clock_pkg::MODE_WAIT && !$past(half_reg) |-> periph_clock_en)
    else $error("peripheral tick missing in wait");
  a_periph_not_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
    periph_clock_en |-> $past(mode_reg) != sys_clock_pkg::MODE_STOP)
    else $error("peripheral clock in stop");
  a_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
    $past(mode_reg) == sys_clock_pkg::MODE_STOP |-> gate_one_clock_en == 16'h0000 && !second_controller_area_clock_en)
    else $error("gated clock in stop");
  a_gate_follow: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    gate_one_clock_en == ({16{periph_clock_en}} & $past(peripheral_clock_gate_one_reg)))
    else $error("gated clocks do not follow gate bits");
  a_second_follow: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    second_controller_area_clock_en == (periph_clock_en && $past(peripheral_clock_gate_two_reg)))
    else $error("second controller clock does not follow bit");

  // Single bits of the first gate register, one per peripheral group
  a_gate_quad: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    periph_clock_en && $past(peripheral_clock_gate_one_reg[10]) |-> gate_one_clock_en[10])
    else $error("quadrature decoder clock missing");
  a_gate_timer: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    periph_clock_en && $past(peripheral_clock_gate_one_reg[9]) |-> gate_one_clock_en[9])
    else $error("timer clock missing");
  a_gate_serial: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    periph_clock_en && $past(peripheral_clock_gate_one_reg[5]) |-> gate_one_clock_en[5])
    else $error("serial unit clock missing");
  a_gate_spi: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    periph_clock_en && $past(peripheral_clock_gate_one_reg[3]) |-> gate_one_clock_en[3])
    else $error("spi unit clock missing");
  a_gate_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    periph_clock_en && $past(peripheral_clock_gate_one_reg[1]) |-> gate_one_clock_en[1])
    else $error("pulse modulator clock missing");
  a_gate_upper: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
    periph_clock_en && $past(peripheral_clock_gate_one_reg[12]) |-> gate_one_clock_en[12])
    else $error("upper peripheral clock missing");

  // A gated tick never lasts two cycles, whatever the gate bit does
  a_no_runt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
    gate_one_clock_en[0] |=> !gate_one_clock_en[0])
    else $error("gated tick stretched");
  a_second_no_runt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
    second_controller_area_clock_en |=> !second_controller_area_clock_en)
    else $error("second controller tick stretched");

  // ****************************************
  // Register and address checks
  // ****************************************
  // A write lands at the access edge only
  a_gate_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    wr_acc && idx == `IDX_GATE_ONE |=> peripheral_clock_gate_one_reg == $past(pwdata[15:0]))
    else $error("gate one write lost");
  a_gate_two_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    wr_acc && idx == `IDX_GATE_TWO |=> peripheral_clock_gate_two_reg == $past(pwdata[0]))
    else $error("gate two write lost");
  a_page_low_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    wr_acc && idx == `IDX_PAGE_LOW |=> short_io_page_low_reg == $past(pwdata[15:0]))
    else $error("page low write lost");
  a_page_high_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    wr_acc && idx == `IDX_PAGE_HIGH |=> short_io_page_high_reg == $past(pwdata[1:0]))
    else $error("page high write lost");
  a_page_high_ones: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    ##1 $past(rd_acc && idx == `IDX_PAGE_HIGH) |-> prdata[15:2] == 14'h3FFF)
    else $error("page high upper bits not ones");
  a_gate_read: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    ##1 $past(rd_acc && idx == `IDX_GATE_ONE) |-> prdata == {16'h0000, $past(peripheral_clock_gate_one_reg)})
    else $error("gate one read mismatch");

  // Offset passes with one register stage; block flag tracks the page
  a_offset_pass: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    $past(presetn) |-> short_address[5:0] == $past(short_offset))
    else $error("short offset not passed");
  a_jtag_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    !$past(off_chip_program_select) |-> !debug_jtag_blocked)
    else $error("debug blocked on on-chip program");
  a_jtag_top: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    debug_jtag_blocked == ($past(off_chip_program_select) && short_address[23:6] != 18'h3FFFF))
    else $error("debug block does not track page");
endmodule

// ==== design/sys_clock_params.svh ====
/*
  Constants for the system clock gate and short I/O page block.
  Assumes a 32-bit APB slave, byte addresses four times the printed index.
*/
// What this block does
// (RULE1) Gate bit one passes clock, zero withholds
// (RULE2) Gate one bits 11,10: quadrature decoders 1,0
// (RULE3) Gate one bits 9..6: timers D..A
// (RULE4) Gate one bits 5,4: serial units 1,0
// (RULE5) Gate one bits 3,2: SPI units 1,0
// (RULE6) Gate one bits 1,0: pulse modulators B,A
// (RULE7) Gate two bits 15..1 read zero
// (RULE8) Gate two bit 0: second CAN controller
// (RULE9) Short address: low six from instruction
// (RULE10) Page high holds bits 23:22, rest ones
// (RULE11) Page low holds address bits 21:6
// (RULE12) Page registers reset to all ones
// (RULE13) New page value effective three cycles later
// (RULE14) Off-top page plus off-chip blocks JTAG debug
// (RULE15) System and peripheral clocks at half master
// (RULE16) Run mode: core and peripheral clocks active
// (RULE17) Wait mode: core stops, peripherals run
// (RULE18) Unmasked interrupt in Wait restores core
// (RULE19) Stop exits only on listed wake events
// (RULE20) CAN wake from Stop loses first message
// (RULE21) Peripherals except watchdog use peripheral clock
// (RULE22) Gate one bits 15..12: memory port, converters, CAN
// (RULE23) Gating changes produce no shortened clock pulses
`ifndef SYS_CLOCK_PARAMS_SVH
`define SYS_CLOCK_PARAMS_SVH
`define IDX_GATE_ONE 4'hC
`define IDX_PAGE_HIGH 4'hD
`define IDX_PAGE_LOW 4'hE
`define IDX_GATE_TWO 4'hF
`define IDX_POWER_CTRL 4'h0
`define RESET_GATE_ONE 16'hFFFF
`define RESET_GATE_TWO 16'h0001
`define RESET_PAGE 16'hFFFF
`define PAGE_HIGH_ONES 16'hFFFC
`define PAGE_DELAY 3
`define PSLVERR_NONE 1'b0
`endif

// ==== design/sys_clock_pkg.sv ====
/*
  Types for the system clock gate block.
  Assumes the params header is compiled alongside.
*/
package sys_clock_pkg;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STOP = 2'b11
  } power_mode_type;
  typedef struct packed {
    logic stop_req;
    logic wait_req;
  } power_req_type;
  typedef struct packed {
    logic can_activity;
    logic unclocked_irq;
    logic watchdog_rst;
    logic external_rst;
  } wake_type;
endpackage

// ==== verification/periph_model.sv ====
/*
  Peripheral-side model: counts core and peripheral enable pulses, flags the gated enables each consumer sees.
  Assumes enables are one-cycle pulses on pclk; clr restarts all counts.
*/
`timescale 1ns/1ps
module periph_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic core_clock_en,
  input wire logic periph_clock_en,
  input wire logic [15:0] gate_one_clock_en,
  input wire logic second_en,
  input wire logic drop,
  output logic [7:0] core_cnt,
  output logic [7:0] periph_cnt,
  output logic [15:0] gate_seen,
  output logic second_seen,
  output logic drop_seen
);
  // A peripheral only advances on its own enable pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_cnt <= 8'h00;
      periph_cnt <= 8'h00;
      gate_seen <= 16'h0000;
      second_seen <= 1'b0;
      drop_seen <= 1'b0;
    end else if (clr) begin
      core_cnt <= 8'h00;
      periph_cnt <= 8'h00;
      gate_seen <= 16'h0000;
      second_seen <= 1'b0;
      drop_seen <= 1'b0;
    end else begin
      core_cnt <= core_cnt + {7'h00, core_clock_en};
      periph_cnt <= periph_cnt + {7'h00, periph_clock_en};
      gate_seen <= gate_seen | gate_one_clock_en;
      second_seen <= second_seen | second_en;
      drop_seen <= drop_seen | drop; // CAN controller discards its first frame
    end
  end
endmodule

// ==== verification/test_sys_clock_gate.sv ====
/*
  Self-checking bench for sys_clock_gate over APB.
  Assumes 20 ns pclk and zero-wait APB answers, though it waits on pready.
*/
`timescale 1ns/1ps
module test_sys_clock_gate;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [5:0] paddr = 6'h00, short_offset = 6'h15;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq = 1'b0, off_chip = 1'b0, clr = 1'b0, jtag_blk, drop, core_en, per_en, sec_en, sec_seen, drp;
  sys_clock_pkg::power_req_type power_req = 2'b00;
  sys_clock_pkg::wake_type wake = 4'h0;
  logic [23:0] short_address;
  logic [15:0] gate_en, gate_seen;
  logic [1:0] power_mode;
  logic [7:0] core_cnt, per_cnt;
  int num_errors = 0, n_tests = 0, cyc = 0;
  sys_clock_gate dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_req(power_req), .wake(wake), .periph_irq_unmasked(irq), .off_chip_program_select(off_chip),
    .short_offset(short_offset), .short_address(short_address), .debug_jtag_blocked(jtag_blk),
    .core_clock_en(core_en), .periph_clock_en(per_en), .gate_one_clock_en(gate_en),
    .second_controller_area_clock_en(sec_en), .can_first_msg_drop(drop), .power_mode(power_mode));
  periph_model peer (.pclk(pclk), .presetn(presetn), .clr(clr), .core_clock_en(core_en),
    .periph_clock_en(per_en), .gate_one_clock_en(gate_en), .second_en(sec_en), .drop(drop),
    .core_cnt(core_cnt), .periph_cnt(per_cnt), .gate_seen(gate_seen), .second_seen(sec_seen), .drop_seen(drp));
  always #10 pclk = ~pclk;
  // Hang guard, well above the under two hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Restart peer counts, then let the enables run for 20 cycles
  task automatic count20();
    @(posedge pclk) clr <= 1'b1;
    @(posedge pclk) clr <= 1'b0;
    repeat (20) @(posedge pclk);
    #1;
  endtask
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 10 && power_mode !== m; i++) @(posedge pclk);
    #1;
    chk("power_mode", {30'h0, m}, {30'h0, power_mode});
  endtask
  task automatic t_regs();
    logic [5:0] a[5] = '{6'h30, 6'h34, 6'h38, 6'h3C, 6'h00};
    logic [15:0] e[5] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk("reset value", {16'h0, e[i]}, rd);
    end
    chk("short_address reset", 32'h00FFFFD5, {8'h0, short_address});
    chk("pslverr", 32'h0, {31'h0, pslverr});
    apb(1'b1, 6'h3C, 32'hFFFE);
    apb(1'b0, 6'h3C, 32'h0);
    chk("gate_two", 32'h0, rd);
    apb(1'b1, 6'h34, 32'h0);
    apb(1'b0, 6'h34, 32'h0);
    chk("page_high", 32'hFFFC, rd);
    apb(1'b1, 6'h10, 32'h5A5A);
    apb(1'b0, 6'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_gate(input logic [15:0] g, input logic s);
    apb(1'b1, 6'h30, {16'h0, g});
    apb(1'b1, 6'h3C, {31'h0, s});
    count20();
    chk("gate_seen", {16'h0, g}, {16'h0, gate_seen});
    chk("second_seen", {31'h0, s}, {31'h0, sec_seen});
    chk("periph_cnt", 32'd10, {24'h0, per_cnt});
    chk("core_cnt", 32'd10, {24'h0, core_cnt});
  endtask
  task automatic t_page();
    chk("jtag_blocked idle", 32'h0, {31'h0, jtag_blk});
    @(posedge pclk) off_chip <= 1'b1;
    apb(1'b1, 6'h34, 32'h1);
    repeat (3) @(posedge pclk);
    apb(1'b1, 6'h38, 32'h1234);
    #1;
    repeat (2) @(posedge pclk);
    #1;
    chk("short_address old", {8'h0, 2'h1, 16'hFFFF, 6'h15}, {8'h0, short_address});
    @(posedge pclk);
    #1;
    chk("short_address", {8'h0, 2'h1, 16'h1234, 6'h15}, {8'h0, short_address});
    chk("jtag_blocked", 32'h1, {31'h0, jtag_blk});
  endtask
  task automatic t_power();
    @(posedge pclk) power_req <= 2'b01;
    wait_mode(2'b01);
    @(posedge pclk) power_req <= 2'b00;
    count20();
    chk("wait core_cnt", 32'd0, {24'h0, core_cnt});
    chk("wait periph_cnt", 32'd10, {24'h0, per_cnt});
    @(posedge pclk) irq <= 1'b1;
    wait_mode(2'b00);
    @(posedge pclk) power_req <= 2'b10;
    wait_mode(2'b11);
    @(posedge pclk) power_req <= 2'b00;
    count20();
    chk("stop periph_cnt", 32'd0, {24'h0, per_cnt});
    chk("stop mode held", 32'h3, {30'h0, power_mode});
    @(posedge pclk) irq <= 1'b0;
    wake <= 4'h8;
    wait_mode(2'b00);
    @(posedge pclk) wake <= 4'h0;
    repeat (4) @(posedge pclk);
    #1;
    chk("first_msg_drop", 32'h1, {31'h0, drp});
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_gate(16'h0A5A, 1'b0);
    t_gate(16'hF5A5, 1'b1);
    t_page();
    t_power();
    results();
  end
endmodule
